// file: common/urb_pkg.sv
// Shared constants and types for the serial receive buffer block.
// Assumes both ends run on one 10 MHz clock with a synchronous reset.
package urb_pkg;

	////////////////////////////////////////////////////////////////////////
	// Clock and bit timing
	localparam int unsigned CLK_HZ        = 10_000_000;
	localparam int unsigned BAUD_DEF      = 625_000;
	localparam int unsigned BIT_CLKS_DEF  = CLK_HZ / BAUD_DEF;
	localparam int unsigned CNT_W         = 16;

	////////////////////////////////////////////////////////////////////////
	// Register byte addresses
	localparam logic [3:0] ADDR_STATUS    = 4'h0;
	localparam logic [3:0] ADDR_CTRL_B    = 4'h4;
	localparam logic [3:0] ADDR_CTRL_C    = 4'h8;
	localparam logic [3:0] ADDR_DATA      = 4'hC;

	// Status register fields
	localparam int unsigned ST_RXC        = 7;
	localparam int unsigned ST_FE         = 4;
	localparam int unsigned ST_DOR        = 3;
	localparam int unsigned ST_PE         = 2;
	// Control register B fields
	localparam int unsigned CB_RXCIE      = 7;
	localparam int unsigned CB_RXEN       = 4;
	localparam int unsigned CB_RXB8       = 1;
	// Control register C fields
	localparam int unsigned CC_PM_HI      = 5;
	localparam int unsigned CC_PM_LO      = 4;
	localparam int unsigned CC_STOP       = 3;
	localparam int unsigned CC_SIZE_HI    = 2;

	////////////////////////////////////////////////////////////////////////
	// Reset values, character sizes and buffer depth
	localparam logic [2:0] SIZE_RST       = 3'h3;
	localparam logic [2:0] SIZE_NINE      = 3'h7;
	localparam logic [3:0] BITS_MIN       = 4'h5;
	localparam logic [3:0] BITS_NINE      = 4'h9;
	localparam int unsigned BUF_DEPTH     = 2;

	// One receive buffer entry
	typedef struct packed {
		logic [8:0] data;
		logic       fe;
		logic       dor;
		logic       pe;
	} urb_entry_t;

	// Receiver frame states
	typedef enum logic [2:0] {
		RX_IDLE  = 3'b000,
		RX_START = 3'b001,
		RX_DATA  = 3'b010,
		RX_PAR   = 3'b011,
		RX_STOP  = 3'b100
	} urb_rx_state_t;

	// Remote transmitter states
	typedef enum logic [2:0] {
		TX_IDLE  = 3'b000,
		TX_START = 3'b001,
		TX_DATA  = 3'b010,
		TX_PAR   = 3'b011,
		TX_STOP1 = 3'b100,
		TX_STOP2 = 3'b101
	} urb_tx_state_t;

endpackage : urb_pkg

// file: common/urb_link_if.sv
// Serial line between the remote transmitter and the receiver.
// Assumes the line idles high and both ends share clk_in.
interface urb_link_if;
	logic serial_line;

	// Remote transmitter drives the line
	modport remote (output serial_line);
	// Receiver samples the line
	modport device (input serial_line);
endinterface : urb_link_if

// file: hw/urb_tx_remote.sv
// Remote serial transmitter: sends one frame per accepted request.
// Assumes the user holds send_in and data until ready_out is seen high.
module urb_tx_remote #(
	parameter int unsigned BIT_CLKS = urb_pkg::BIT_CLKS_DEF
) (
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       sys_rst_in,
	// Link
	urb_link_if.remote      link,
	// User request
	input  wire logic       send_in,
	input  wire logic [8:0] data_in,
	input  wire logic [3:0] nbits_in,
	input  wire logic       parity_en_in,
	input  wire logic       parity_odd_in,
	input  wire logic       two_stop_in,
	input  wire logic       bad_parity_in,
	input  wire logic       bad_stop_in,
	output logic            ready_out
);
	import urb_pkg::*;

	if (BIT_CLKS < 4 || BIT_CLKS >= (1 << CNT_W)) begin : g_chk
		$error("BIT_CLKS out of range");
	end

	localparam logic [CNT_W-1:0] BIT_LAST = CNT_W'(BIT_CLKS - 1);

	typedef struct packed {
		urb_tx_state_t    fsm;
		logic [CNT_W-1:0] tick;
		logic [3:0]       bitn;
		logic [3:0]       nbits;
		logic [8:0]       shift;
		logic             par;
		logic             par_en;
		logic             two_stop;
		logic             bad_stop;
		logic             line;
	} urb_tx_st_t;

	urb_tx_st_t s_q;
	urb_tx_st_t s_d;

	////////////////////////////////////////////////////////////////////////
	// Frame sequencer
	always_comb begin
		s_d = s_q;
		if (s_q.fsm != TX_IDLE) begin
			s_d.tick = s_q.tick - 1'b1;
		end
		case (s_q.fsm)
			TX_IDLE: begin
				s_d.line = 1'b1;
				if (send_in) begin
					s_d.fsm      = TX_START;
					s_d.tick     = BIT_LAST;
					s_d.line     = 1'b0;
					s_d.shift    = data_in;
					s_d.nbits    = nbits_in;
					s_d.bitn     = 4'h0;
					// Parity over the bits actually sent, not all nine
					s_d.par      = ^(data_in & ~(9'h1FF << nbits_in)) ^ parity_odd_in ^ bad_parity_in;
					s_d.par_en   = parity_en_in;
					s_d.two_stop = two_stop_in;
					s_d.bad_stop = bad_stop_in;
				end
			end
			TX_START, TX_DATA: begin
				if (s_q.tick == '0) begin
					s_d.tick = BIT_LAST;
					if (s_q.fsm == TX_DATA && s_q.bitn == s_q.nbits) begin
						s_d.fsm  = s_q.par_en ? TX_PAR : TX_STOP1;
						s_d.line = s_q.par_en ? s_q.par : ~s_q.bad_stop;
					end else begin
						s_d.fsm   = TX_DATA;
						s_d.line  = s_q.shift[0];
						s_d.shift = {1'b0, s_q.shift[8:1]};
						s_d.bitn  = s_q.bitn + 1'b1;
					end
				end
			end
			TX_PAR: begin
				if (s_q.tick == '0) begin
					s_d.tick = BIT_LAST;
					s_d.fsm  = TX_STOP1;
					s_d.line = ~s_q.bad_stop;
				end
			end
			TX_STOP1, TX_STOP2: begin
				if (s_q.tick == '0) begin
					s_d.tick = BIT_LAST;
					s_d.line = 1'b1;
					s_d.fsm  = (s_q.fsm == TX_STOP1 && s_q.two_stop) ? TX_STOP2 : TX_IDLE;
				end
			end
			default: begin
				s_d.fsm = TX_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			s_q      <= '0;
			s_q.fsm  <= TX_IDLE;
			s_q.line <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs
	assign ready_out        = (s_q.fsm == TX_IDLE);
	assign link.serial_line = s_q.line;

endmodule : urb_tx_remote

// file: hw/urb_rx_device.sv
// Serial receiver with a two-entry buffer, per-character error flags and
// an Avalon-MM register slave with waitrequest.
// Assumes the serial line and bus inputs are synchronous to clk_in.
//
// Our own choices: register access over Avalon-MM and the placing of the registers.
module urb_rx_device #(
	parameter int unsigned BIT_CLKS = urb_pkg::BIT_CLKS_DEF
) (
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        sys_rst_in,
	// Link
	urb_link_if.device       link,
	// Avalon-MM slave
	input  wire logic [3:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	input  wire logic [3:0]  avs_byteenable_in,
	output logic [31:0]      avs_readdata_out,
	output logic             avs_waitrequest_out,
	// System
	input  wire logic        global_irq_enable_in,
	output logic             rx_irq_request_out,
	output logic             pin_override_out
);
	import urb_pkg::*;

	if (BIT_CLKS < 4 || BIT_CLKS >= (1 << CNT_W)) begin : g_chk
		$error("BIT_CLKS out of range");
	end

	localparam logic [CNT_W-1:0] BIT_LAST  = CNT_W'(BIT_CLKS - 1);
	localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(BIT_CLKS / 2 - 1);

	typedef struct packed {
		urb_rx_state_t        fsm;
		logic [CNT_W-1:0]     tick;
		logic [3:0]           bitn;
		logic [8:0]           shift;
		logic                 par_bit;
		logic                 line_prev;
		logic                 pend_v;
		urb_entry_t           pend;
		logic                 lost;
		urb_entry_t [1:0]     fifo;
		logic                 rd_idx;
		logic [1:0]           cnt;
		logic                 rx_en;
		logic                 irq_en;
		logic [1:0]           pmode;
		logic                 stop2;
		logic [2:0]           size;
		logic                 ack;
		logic [31:0]          rdata;
	} urb_rx_st_t;

	urb_rx_st_t s_q;
	urb_rx_st_t s_d;

	logic       line;
	logic       req;
	logic       has_data;
	logic [3:0] nbits;
	urb_entry_t head;
	urb_entry_t done;

	assign line     = link.serial_line;
	assign req      = avs_read_in | avs_write_in;
	assign has_data = (s_q.cnt != 2'h0);
	assign head     = s_q.fifo[s_q.rd_idx];
	assign nbits    = (s_q.size == SIZE_NINE) ? BITS_NINE :
	                  (s_q.size[2] ? BITS_MIN + 4'h3 : BITS_MIN + {2'b00, s_q.size[1:0]});

	////////////////////////////////////////////////////////////////////////
	// Completed frame, aligned and checked
	always_comb begin
		done.data = s_q.shift >> (BITS_NINE - nbits);
		done.fe   = ~line;
		done.dor  = 1'b0;
		// Checker on only with upper mode bit; lower picks odd
		done.pe   = s_q.pmode[1] & (^done.data ^ s_q.par_bit ^ s_q.pmode[0]);
	end

	////////////////////////////////////////////////////////////////////////
	// Bus slave, buffer and frame sequencer
	always_comb begin
		s_d           = s_q;
		s_d.line_prev = line;

		// Bus: capture read data first cycle, commit on acknowledge
		if (req && !s_q.ack) begin
			s_d.ack = 1'b1;
			case (avs_address_in)
				ADDR_STATUS: s_d.rdata = {24'h0, has_data, 2'b00,
				                          has_data & head.fe, has_data & head.dor,
				                          has_data & head.pe, 2'b00};
				ADDR_CTRL_B: s_d.rdata = {24'h0, s_q.irq_en, 2'b00, s_q.rx_en, 2'b00,
				                          has_data & head.data[8], 1'b0};
				ADDR_CTRL_C: s_d.rdata = {26'h0, s_q.pmode, s_q.stop2, s_q.size};
				ADDR_DATA:   s_d.rdata = {24'h0, has_data ? head.data[7:0] : 8'h00};
				default:     s_d.rdata = 32'h0;
			endcase
		end else if (req && s_q.ack) begin
			s_d.ack = 1'b0;
			if (avs_write_in && avs_byteenable_in[0]) begin
				// Status writes have no effect on the error flags
				if (avs_address_in == ADDR_CTRL_B) begin
					s_d.irq_en = avs_writedata_in[CB_RXCIE];
					s_d.rx_en  = avs_writedata_in[CB_RXEN];
				end else if (avs_address_in == ADDR_CTRL_C) begin
					s_d.pmode = {avs_writedata_in[CC_PM_HI], avs_writedata_in[CC_PM_LO]};
					s_d.stop2 = avs_writedata_in[CC_STOP];
					s_d.size  = avs_writedata_in[CC_SIZE_HI:0];
				end
			end
			// Data read pops the head entry and frees it
			if (avs_read_in && avs_address_in == ADDR_DATA && has_data) begin
				s_d.rd_idx = ~s_q.rd_idx;
				s_d.cnt    = s_q.cnt - 2'h1;
			end
		end

		// Waiting frame enters the buffer once room exists
		if (s_q.pend_v && s_d.cnt < 2'(BUF_DEPTH)) begin
			s_d.fifo[s_d.rd_idx ^ s_d.cnt[0]]     = s_q.pend;
			s_d.fifo[s_d.rd_idx ^ s_d.cnt[0]].dor = s_q.lost;
			s_d.lost   = 1'b0;
			s_d.pend_v = 1'b0;
			s_d.cnt    = s_d.cnt + 2'h1;
		end

		// Frame sequencer, sampling mid-bit
		if (s_q.fsm != RX_IDLE) begin
			s_d.tick = s_q.tick - 1'b1;
		end
		case (s_q.fsm)
			RX_IDLE: begin
				if (s_q.line_prev && !line) begin
					s_d.fsm  = RX_START;
					s_d.tick = HALF_LAST;
					// Buffer full and a frame already waiting in pend: this frame is lost
					if (s_d.cnt == 2'(BUF_DEPTH) && s_d.pend_v) begin
						s_d.lost = 1'b1;
					end
				end
			end
			RX_START: begin
				if (s_q.tick == '0) begin
					s_d.fsm  = line ? RX_IDLE : RX_DATA;
					s_d.tick = BIT_LAST;
					s_d.bitn = 4'h0;
				end
			end
			RX_DATA: begin
				if (s_q.tick == '0) begin
					s_d.tick  = BIT_LAST;
					s_d.shift = {line, s_q.shift[8:1]};
					s_d.bitn  = s_q.bitn + 4'h1;
					if (s_q.bitn == nbits - 4'h1) begin
						s_d.fsm = s_q.pmode[1] ? RX_PAR : RX_STOP;
					end
				end
			end
			RX_PAR: begin
				if (s_q.tick == '0) begin
					s_d.tick    = BIT_LAST;
					s_d.par_bit = line;
					s_d.fsm     = RX_STOP;
				end
			end
			RX_STOP: begin
				// First stop bit only; further stop bits look like idle
				if (s_q.tick == '0) begin
					s_d.fsm = RX_IDLE;
					if (!s_d.pend_v) begin
						s_d.pend_v = 1'b1;
						s_d.pend   = done;
					end
				end
			end
			default: begin
				s_d.fsm = RX_IDLE;
			end
		endcase

		// Disable is immediate: frame abandoned, buffer flushed
		if (!s_d.rx_en) begin
			s_d.fsm    = RX_IDLE;
			s_d.cnt    = 2'h0;
			s_d.pend_v = 1'b0;
			s_d.lost   = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			s_q           <= '0;
			s_q.fsm       <= RX_IDLE;
			s_q.size      <= SIZE_RST;
			s_q.line_prev <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign avs_readdata_out    = s_q.rdata;
	assign avs_waitrequest_out = req & ~s_q.ack;
	assign rx_irq_request_out  = global_irq_enable_in & s_q.irq_en & has_data;
	assign pin_override_out    = s_q.rx_en;

endmodule : urb_rx_device

// file: testbench/urb_monitor.sv
// Checker for the receive block: bus, interrupt and line relations.
// Assumes it sits beside the link, inputs named as the design ports.
module urb_monitor (
	// Clock, reset and line
	input wire logic        clk_in,
	input wire logic        sys_rst_in,
	input wire logic        serial_line,
	// Register bus and system
	input wire logic [3:0]  avs_address_in,
	input wire logic        avs_read_in,
	input wire logic        avs_write_in,
	input wire logic [31:0] avs_readdata_out,
	input wire logic        avs_waitrequest_out,
	input wire logic        global_irq_enable_in,
	input wire logic        rx_irq_request_out,
	input wire logic        pin_override_out
);
	timeunit 1ns;
	timeprecision 1ns;
	import urb_pkg::*;
	default clocking @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	// Read accepted in this cycle
	wire logic rd_ack = avs_read_in && !avs_waitrequest_out;
	////////////////////////////////////////////////////////////////////////
	a_irq_needs_global: assert property (rx_irq_request_out |-> global_irq_enable_in)
		else $error("irq without global enable");
	a_irq_off_disabled: assert property (!pin_override_out |-> !rx_irq_request_out)
		else $error("irq while receiver off");
	a_irq_holds: assert property ((rx_irq_request_out && !avs_write_in
		&& !(avs_read_in && avs_address_in == ADDR_DATA)) ##1 global_irq_enable_in
		|-> rx_irq_request_out) else $error("irq dropped without data read");
	a_wait_one: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
		|=> !avs_waitrequest_out) else $error("bus answer late");
	a_wait_idle: assert property (!(avs_read_in || avs_write_in) |-> !avs_waitrequest_out)
		else $error("wait without request");
	a_data_byte: assert property (rd_ack && avs_address_in == ADDR_DATA
		|-> avs_readdata_out[31:8] == 24'h0) else $error("data upper bits set");
	a_empty_clean: assert property (rd_ack && avs_address_in == ADDR_STATUS
		&& !avs_readdata_out[ST_RXC] |-> avs_readdata_out == 32'h0)
		else $error("flags while empty");
	a_unmapped_zero: assert property (rd_ack && avs_address_in[1:0] != 2'h0
		|-> avs_readdata_out == 32'h0) else $error("unmapped read not zero");
	a_bit_length: assert property ($fell(serial_line) |-> !serial_line [*8])
		else $error("short low bit on line");
	// Main scenarios reached
	c_irq: cover property (rx_irq_request_out);
	c_overrun: cover property (rd_ack && avs_readdata_out[ST_DOR]);
	c_parity: cover property (rd_ack && avs_readdata_out[ST_PE]);
endmodule : urb_monitor

// file: testbench/testbench.sv
// Self-checking bench: remote transmitter feeds the receiver.
// Assumes package, link interface and both ends compiled first.
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import urb_pkg::*;
	localparam int unsigned BC = 8;
	logic        clk_in = 1'b0;
	logic        sys_rst_in = 1'b1;
	logic [3:0]  addr = 4'h0;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  be = 4'h0;
	logic [31:0] rdata;
	logic        wreq, irq, ovr, rdy;
	logic        gie = 1'b0;
	logic        send = 1'b0;
	logic [8:0]  txd = 9'h0;
	logic [3:0]  nb = 4'h8;
	logic        pen = 1'b0, podd = 1'b0, two = 1'b0, bpar = 1'b0, bstop = 1'b0;
	logic [31:0] exp_q[$];
	logic [8:0]  v[4];
	int          err_count = 0;
	int          checks_done = 0;
	int          seed = 32'h478ef109;
	////////////////////////////////////////////////////////////////////////
	urb_link_if link_i ();
	urb_tx_remote #(.BIT_CLKS(BC)) urb_tx_remote_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
		.link(link_i), .send_in(send), .data_in(txd), .nbits_in(nb), .parity_en_in(pen),
		.parity_odd_in(podd), .two_stop_in(two), .bad_parity_in(bpar),
		.bad_stop_in(bstop), .ready_out(rdy));
	urb_rx_device #(.BIT_CLKS(BC)) urb_rx_device_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
		.link(link_i), .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
		.avs_writedata_in(wdata), .avs_byteenable_in(be), .avs_readdata_out(rdata),
		.avs_waitrequest_out(wreq), .global_irq_enable_in(gie),
		.rx_irq_request_out(irq), .pin_override_out(ovr));
	urb_monitor urb_monitor_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
		.serial_line(link_i.serial_line), .avs_address_in(addr), .avs_read_in(rd),
		.avs_write_in(wr), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
		.global_irq_enable_in(gie), .rx_irq_request_out(irq), .pin_override_out(ovr));
	// Clock
	always #50 clk_in = ~clk_in;
	////////////////////////////////////////////////////////////////////////
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	// Acknowledged read meets the oldest note
	always @(posedge clk_in) begin
		if (rd && wreq === 1'b0) cmp(rdata, exp_q.pop_front());
	end
	// One Avalon transfer, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_in);
		addr <= a;
		wdata <= d;
		be <= 4'hF;
		rd <= !w;
		wr <= w;
		do @(posedge clk_in); while (wreq !== 1'b0);
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus
	task automatic rdx(input logic [3:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask : rdx
	// One frame handed to the remote end
	task automatic tx(input logic [8:0] d);
		@(posedge clk_in);
		txd <= d;
		send <= 1'b1;
		do @(posedge clk_in); while (rdy !== 1'b1);
		send <= 1'b0;
	endtask : tx
	// Wait for the line to go idle and the frame to land
	task automatic settle();
		repeat (2) @(posedge clk_in);
		do @(posedge clk_in); while (rdy !== 1'b1);
		repeat (3) @(posedge clk_in);
	endtask : settle
	// Status, ninth bit, then data of the head entry
	task automatic pull(input logic [8:0] d, input int n, input logic [7:0] st);
		logic [8:0] m;
		m = d & 9'((1 << n) - 1);
		rdx(ADDR_STATUS, {24'h0, st});
		if (n == 9) rdx(ADDR_CTRL_B, {24'h0, 8'h10 | {6'h0, m[8], 1'b0}});
		rdx(ADDR_DATA, {24'h0, m[7:0]});
	endtask : pull
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : give_verdict
	// Watchdog
	initial begin
		repeat (30000) @(posedge clk_in);
		err_count++;
		give_verdict();
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		bus(1'b1, ADDR_CTRL_B, 32'h10);
		// Size codes 0 to 3 and 7, two frames back to back
		for (int i = 0; i < 5; i++) begin
			bus(1'b1, ADDR_CTRL_C, (i == 4) ? 32'h7 : i);
			nb <= (i == 4) ? BITS_NINE : 4'(i + 5);
			v[0] = 9'($random(seed));
			tx(v[0]);
			tx(~v[0]);
			settle();
			pull(v[0], (i == 4) ? 9 : i + 5, 8'h80);
			pull(~v[0], (i == 4) ? 9 : i + 5, 8'h80);
			rdx(ADDR_STATUS, 32'h0);
		end
		$display("size test done");
		// Parity modes, odd one sent right, even one wrong
		for (int k = 0; k < 4; k++) begin
			bus(1'b1, ADDR_CTRL_C, 32'h3 | (k << 4));
			{nb, pen, podd, two, bpar, bstop} <= {4'h8, k[1], k[0], 1'b0, !k[0], 1'b0};
			v[0] = 9'($random(seed));
			tx(v[0]);
			settle();
			pull(v[0], 8, 8'h80 | {5'h0, k[1] & !k[0], 2'h0});
		end
		$display("parity test done");
		// First stop bit only, flags kept over status write
		bus(1'b1, ADDR_CTRL_C, 32'hB);
		for (int k = 0; k < 2; k++) begin
			{pen, podd, two, bpar, bstop} <= {3'b001, 1'b0, !k[0]};
			tx(v[0]);
			settle();
			bus(1'b1, ADDR_STATUS, 32'hFF);
			pull(v[0], 8, k ? 8'h80 : 8'h90);
		end
		rdx(4'h2, 32'h0);
		$display("frame test done");
		// Overrun: fourth frame lost, third marked
		bus(1'b1, ADDR_CTRL_C, 32'h3);
		{two, bstop} <= 2'b00;
		for (int k = 0; k < 4; k++) begin
			v[k] = 9'($random(seed));
			tx(v[k]);
		end
		settle();
		pull(v[0], 8, 8'h80);
		pull(v[1], 8, 8'h80);
		pull(v[2], 8, 8'h88);
		rdx(ADDR_STATUS, 32'h0);
		tx(v[3]);
		settle();
		pull(v[3], 8, 8'h80);
		$display("overrun test done");
		// Flush by data reads until the complete flag clears
		tx(v[0]);
		tx(v[1]);
		settle();
		for (int k = 0; k < 2; k++) begin
			rdx(ADDR_STATUS, 32'h80);
			rdx(ADDR_DATA, {24'h0, v[k][7:0]});
		end
		rdx(ADDR_STATUS, 32'h0);
		$display("flush test done");
		// Interrupt follows the complete flag
		gie <= 1'b1;
		bus(1'b1, ADDR_CTRL_B, 32'h90);
		tx(v[1]);
		settle();
		cmp({31'h0, irq}, 32'h1);
		rdx(ADDR_CTRL_B, 32'h90);
		rdx(ADDR_DATA, {24'h0, v[1][7:0]});
		// Pop lands on the acknowledge edge; look one edge later
		@(posedge clk_in);
		cmp({31'h0, irq}, 32'h0);
		$display("irq test done");
		// Disable mid-frame flushes and releases the pin
		tx(v[0]);
		tx(v[2]);
		repeat (3 * BC) @(posedge clk_in);
		bus(1'b1, ADDR_CTRL_B, 32'h0);
		@(posedge clk_in);
		cmp({31'h0, ovr}, 32'h0);
		settle();
		bus(1'b1, ADDR_CTRL_B, 32'h10);
		rdx(ADDR_STATUS, 32'h0);
		tx(v[3]);
		settle();
		pull(v[3], 8, 8'h80);
		$display("disable test done");
		give_verdict();
	end
endmodule : testbench
